// ---- logic/dca_sync.sv ----
// shared constants for the dram command/address input block, and the
// two-flop pin synchroniser. assumes one clock, async active-low reset.
`timescale 1ns/10ps
`default_nettype none

package dca_pkg;
	// command code is {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam int AP_BIT = 10;
	localparam int BC_BIT = 12;
	localparam int TERMINATION_STROBE_COMP_BIT = 11;
	localparam int BA_MR_MSB = 2;
	localparam int MR1_RTT_B0 = 2;
	localparam int MR1_RTT_B1 = 6;
	localparam int MR1_RTT_B2 = 9;
	localparam int MR2_RTTWR_LO = 9;
	localparam int MR2_RTTWR_HI = 10;
	localparam logic [1:0] MR0_BL_OTF = 2'h1;
	localparam logic [1:0] MR_IDX_ZERO = 2'h0;
	localparam logic [1:0] MR_IDX_ONE = 2'h1;
	localparam logic [1:0] MR_IDX_TWO = 2'h2;
	localparam logic [14:0] MR_RESET = 15'h0000;
	localparam logic [3:0] BEATS_FULL = 4'h8;
	localparam logic [3:0] BEATS_CHOP = 4'h4;
	typedef enum {PWR_ACTIVE, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF} dca_pwr_e;
endpackage

////////////////////////////////////////////////////////////////////////////////

module dca_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// meta_reg is read by q only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

`default_nettype wire

// ---- logic/dca_top.sv ----
// command, address and control input logic of a ddr dram device.
// assumes pins arrive unsynchronised; ref_clk much faster than the pin clock.
`timescale 1ns/10ps
`default_nettype none

module dca_top #(
	parameter int BANK_W = 3,
	parameter int ROW_W = 15,
	parameter int COL_W = 10
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic diff_clock_true,
	input wire logic diff_clock_comp,
	input wire logic clock_gate,
	input wire logic chip_select_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_enable_n,
	input wire logic [BANK_W-1:0] bank_select,
	input wire logic [ROW_W-1:0] address_bus,
	input wire logic termination_enable,
	input wire logic write_mask,
	input wire logic data_strobe,
	output logic cmd_valid,
	output logic [3:0] cmd_code,
	output logic [BANK_W-1:0] cmd_bank,
	output logic [ROW_W-1:0] row_addr,
	output logic [COL_W-1:0] col_addr,
	output logic auto_precharge,
	output logic precharge_all,
	output logic burst_chop,
	output logic [(1<<BANK_W)-1:0] open_banks,
	output logic clocks_enable,
	output logic buffers_enable,
	output logic self_refresh,
	output logic active_power_down,
	output logic precharge_power_down,
	output logic termination_on,
	output logic termination_strobe_on,
	output logic mask_mode,
	output logic beat_valid,
	output logic beat_discard
);
	localparam int NB = 1 << BANK_W;
	localparam int SW = 10 + BANK_W + ROW_W;

	if (ROW_W <= dca_pkg::BC_BIT || COL_W > ROW_W || BANK_W <= dca_pkg::BA_MR_MSB) begin : g_chk
		$error("dca_top: address or bank width too small");
	end

	function automatic logic is_access(input logic [3:0] c);
		is_access = (c == dca_pkg::CMD_RD) || (c == dca_pkg::CMD_WR);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers

	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	logic [SW-1:0] pins_s;
	logic ckt_s, ckc_s, cke_s, odt_s, dm_s, dqs_s;
	logic [3:0] cmd_s;
	logic [BANK_W-1:0] ba_s;
	logic [ROW_W-1:0] addr_s;

	dca_sync #(.W(SW)) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.d({diff_clock_true, diff_clock_comp, clock_gate, termination_enable,
			write_mask, data_strobe, chip_select_n, row_strobe_n,
			col_strobe_n, write_enable_n, bank_select, address_bus}),
		.q(pins_s)
	);
	assign {ckt_s, ckc_s, cke_s, odt_s, dm_s, dqs_s, cmd_s, ba_s, addr_s} = pins_s;

	////////////////////////////////////////////////////////////////////////////
	// clock crossing detect

	logic ck_prev_reg;
	logic ck_pos;
	logic ck_rise;

	assign ck_pos = ckt_s & ~ckc_s;
	assign ck_rise = ck_pos & ~ck_prev_reg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ck_prev_reg <= 1'b0;
		end else begin
			ck_prev_reg <= ck_pos;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power state

	dca_pkg::dca_pwr_e pwr_reg;
	logic take_cmd;
	logic sr_enter;

	// refresh seen with clock-gate low while active: self-refresh starts at this edge
	assign sr_enter = ck_rise && !cke_s && cmd_s == dca_pkg::CMD_REF
		&& pwr_reg == dca_pkg::PWR_ACTIVE;

	// commands only while clocks run and chip-select low
	assign take_cmd = ck_rise && cke_s && pwr_reg == dca_pkg::PWR_ACTIVE
		&& !cmd_s[3];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_reg <= dca_pkg::PWR_ACTIVE;
		end else begin
			case (pwr_reg)
				dca_pkg::PWR_ACTIVE: begin
					if (ck_rise && !cke_s) begin
						if (cmd_s == dca_pkg::CMD_REF) begin
							pwr_reg <= dca_pkg::PWR_SELF_REF;
						end else if (|open_banks) begin
							pwr_reg <= dca_pkg::PWR_ACT_PD;
						end else begin
							pwr_reg <= dca_pkg::PWR_PRE_PD;
						end
					end
				end
				dca_pkg::PWR_PRE_PD, dca_pkg::PWR_ACT_PD: begin
					if (ck_rise && cke_s) begin
						pwr_reg <= dca_pkg::PWR_ACTIVE;
					end
				end
				dca_pkg::PWR_SELF_REF: begin
					// level alone is enough, input clock may be stopped
					if (cke_s) begin
						pwr_reg <= dca_pkg::PWR_ACTIVE;
					end
				end
				default: pwr_reg <= dca_pkg::PWR_ACTIVE;
			endcase
		end
	end

	assign clocks_enable = pwr_reg == dca_pkg::PWR_ACTIVE;
	assign buffers_enable = pwr_reg == dca_pkg::PWR_ACTIVE;
	assign self_refresh = pwr_reg == dca_pkg::PWR_SELF_REF;
	assign active_power_down = pwr_reg == dca_pkg::PWR_ACT_PD;
	assign precharge_power_down = pwr_reg == dca_pkg::PWR_PRE_PD;

	////////////////////////////////////////////////////////////////////////////
	// command capture

	logic otf_en;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_valid <= 1'b0;
			cmd_code <= dca_pkg::CMD_NOP;
			cmd_bank <= '0;
			row_addr <= '0;
			col_addr <= '0;
			auto_precharge <= 1'b0;
			precharge_all <= 1'b0;
			burst_chop <= 1'b0;
		end else begin
			cmd_valid <= take_cmd;
			if (take_cmd) begin
				cmd_code <= cmd_s;
				cmd_bank <= ba_s;
				row_addr <= addr_s;
				col_addr <= addr_s[COL_W-1:0];
				auto_precharge <= is_access(cmd_s) && addr_s[dca_pkg::AP_BIT];
				precharge_all <= cmd_s == dca_pkg::CMD_PRE && addr_s[dca_pkg::AP_BIT];
				// chop only when burst length is on-the-fly
				burst_chop <= is_access(cmd_s) && otf_en
					&& !addr_s[dca_pkg::BC_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mode registers

	logic [ROW_W-1:0] mr_reg [0:3];
	logic odt_allowed;

	assign otf_en = mr_reg[dca_pkg::MR_IDX_ZERO][1:0] == dca_pkg::MR0_BL_OTF;
	assign mask_mode = !mr_reg[dca_pkg::MR_IDX_ONE][dca_pkg::TERMINATION_STROBE_COMP_BIT];
	assign odt_allowed = mr_reg[dca_pkg::MR_IDX_ONE][dca_pkg::MR1_RTT_B0]
		|| mr_reg[dca_pkg::MR_IDX_ONE][dca_pkg::MR1_RTT_B1]
		|| mr_reg[dca_pkg::MR_IDX_ONE][dca_pkg::MR1_RTT_B2]
		|| |mr_reg[dca_pkg::MR_IDX_TWO][dca_pkg::MR2_RTTWR_HI:dca_pkg::MR2_RTTWR_LO];

	// upper bank bit must be zero for a valid register select
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				mr_reg[i] <= ROW_W'(dca_pkg::MR_RESET);
			end
		end else if (take_cmd && cmd_s == dca_pkg::CMD_MRS && !ba_s[dca_pkg::BA_MR_MSB]) begin
			mr_reg[ba_s[1:0]] <= addr_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bank row tracking

	// auto-precharge closes the row at command time, burst timing not modelled
	for (genvar b = 0; b < NB; b++) begin : g_bank
		logic hit;
		assign hit = ba_s == BANK_W'(b);
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				open_banks[b] <= 1'b0;
			end else if (take_cmd) begin
				if (cmd_s == dca_pkg::CMD_ACT && hit) begin
					open_banks[b] <= 1'b1;
				end else if (cmd_s == dca_pkg::CMD_PRE
					&& (hit || addr_s[dca_pkg::AP_BIT])) begin
					open_banks[b] <= 1'b0;
				end else if (is_access(cmd_s) && hit && addr_s[dca_pkg::AP_BIT]) begin
					open_banks[b] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// termination

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			termination_on <= 1'b0;
		// the entry edge counts too, else the pin level leaks into the first cycle
		end else if (pwr_reg == dca_pkg::PWR_SELF_REF || sr_enter || !odt_allowed) begin
			termination_on <= 1'b0;
		end else if (ck_rise) begin
			termination_on <= odt_s;
		end
	end

	assign termination_strobe_on = termination_on && !mask_mode;

	////////////////////////////////////////////////////////////////////////////
	// write mask on both strobe edges

	logic dqs_prev_reg;
	logic [3:0] beats_reg;
	logic dqs_edge;

	assign dqs_edge = dqs_s ^ dqs_prev_reg;

	// beats counted from the first strobe edge after the write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dqs_prev_reg <= 1'b0;
			beats_reg <= '0;
			beat_valid <= 1'b0;
			beat_discard <= 1'b0;
		end else begin
			dqs_prev_reg <= dqs_s;
			beat_valid <= 1'b0;
			beat_discard <= 1'b0;
			if (take_cmd && cmd_s == dca_pkg::CMD_WR) begin
				beats_reg <= (otf_en && !addr_s[dca_pkg::BC_BIT])
					? dca_pkg::BEATS_CHOP : dca_pkg::BEATS_FULL;
			end else if (dqs_edge && beats_reg != '0) begin
				beats_reg <= beats_reg - 4'h1;
				beat_valid <= 1'b1;
				beat_discard <= dm_s && mask_mode;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_cmd_cs_mask: assert property (cmd_valid |-> $past(ck_rise) && !$past(cmd_s[3]))
		else $error("command taken without chip select or clock edge");
	a_auto_pre: assert property (cmd_valid && is_access(cmd_code)
		|-> auto_precharge == $past(addr_s[dca_pkg::AP_BIT]))
		else $error("auto precharge flag wrong");
	a_pre_all: assert property (cmd_valid && cmd_code == dca_pkg::CMD_PRE
		|=> open_banks == '0 || !precharge_all)
		else $error("precharge all left a bank open");
	a_chop_otf: assert property (cmd_valid && !$past(otf_en) |-> !burst_chop)
		else $error("burst chop without on-the-fly mode");
	a_sr_buffers: assert property (self_refresh |-> !buffers_enable && !termination_on)
		else $error("buffers or termination on in self refresh");
	a_sr_exit: assert property (self_refresh && cke_s |=> clocks_enable)
		else $error("self refresh exit missed");
	a_pd_kind: assert property ($rose(active_power_down) |-> $past(|open_banks))
		else $error("active power down with all banks idle");
	a_mrs_load: assert property (cmd_valid && cmd_code == dca_pkg::CMD_MRS
		&& cmd_bank == BANK_W'(dca_pkg::MR_IDX_ONE)
		|-> mr_reg[dca_pkg::MR_IDX_ONE] == row_addr)
		else $error("mode register one not loaded");
	a_act_open: assert property (cmd_valid && cmd_code == dca_pkg::CMD_ACT
		|-> open_banks[cmd_bank])
		else $error("activated bank not open");
	a_mask_drop: assert property (beat_valid
		|-> beat_discard == $past(dm_s && mask_mode))
		else $error("mask beat handling wrong");

	c_mrs: cover property (cmd_valid && cmd_code == dca_pkg::CMD_MRS);
	c_discard: cover property (beat_valid && beat_discard);
	c_self_ref: cover property ($rose(self_refresh));
	c_act_pd: cover property ($rose(active_power_down));
endmodule

`default_nettype wire

// ---- sim/dca_ctrl_model.sv ----
// memory controller model: pin clock, command/address pins, odt, mask and strobe.
// assumes the bench calls its tasks; pin clock halves of 32 ns.
`timescale 1ns/10ps
`default_nettype none

module dca_ctrl_model (
	output logic diff_clock_true,
	output logic diff_clock_comp,
	output logic clock_gate,
	output logic chip_select_n,
	output logic row_strobe_n,
	output logic col_strobe_n,
	output logic write_enable_n,
	output logic [2:0] bank_select,
	output logic [14:0] address_bus,
	output logic termination_enable,
	output logic write_mask,
	output logic data_strobe
);
	logic ck_run;

	// stops only while low, so a stop never makes a rising edge
	initial begin
		ck_run = 1'b0;
		{diff_clock_true, diff_clock_comp, clock_gate} = 3'h3;
		{chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'hF;
		{bank_select, address_bus} = 18'h00000;
		{termination_enable, write_mask, data_strobe} = 3'h0;
		forever begin
			#32;
			if (ck_run || diff_clock_true) begin
				diff_clock_true = ~diff_clock_true;
			end
			diff_clock_comp = ~diff_clock_true;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// pins change 1 ns after the fall, stay put over the rise, then go stale
	task drive(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a,
		input logic k, input logic o);
		@(negedge diff_clock_true);
		#1;
		{chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = c;
		bank_select = b;
		address_bus = a;
		clock_gate = k;
		termination_enable = o;
		@(posedge diff_clock_true);
		#20;
		chip_select_n = 1'b1;
		bank_select = ~bank_select;
		address_bus = ~address_bus;
	endtask

	// mask held 16 ns either side of every strobe toggle
	task beats(input logic [7:0] m);
		for (int i = 0; i < 8; i++) begin
			write_mask = m[i];
			#16;
			data_strobe = ~data_strobe;
			#16;
		end
		write_mask = ~write_mask;
	endtask

	// clock-gate rises while the pin clock stands still
	task sr_exit;
		ck_run = 1'b0;
		#100;
		clock_gate = 1'b1;
		#100;
		ck_run = 1'b1;
	endtask
endmodule

`default_nettype wire

// ---- sim/dram_command_address_input_bench.sv ----
// self-checking bench for dca_top driven by the controller model.
// assumes dca_pkg is compiled first; 5 ns system clock.
`timescale 1ns/10ps
`default_nettype none

module dram_command_address_input_bench;
	logic ref_clk, resetn, diff_clock_true, diff_clock_comp, clock_gate, chip_select_n;
	logic row_strobe_n, col_strobe_n, write_enable_n, termination_enable, write_mask;
	logic data_strobe, cmd_valid, auto_precharge, precharge_all, burst_chop, clocks_enable;
	logic buffers_enable, self_refresh, active_power_down, precharge_power_down;
	logic termination_on, termination_strobe_on, mask_mode, beat_valid, beat_discard;
	logic [2:0] bank_select, cmd_bank;
	logic [14:0] address_bus, row_addr;
	logic [3:0] cmd_code;
	logic [9:0] col_addr;
	logic [7:0] open_banks, eo;
	logic otf;
	int bad_count, compares, vcnt, bcnt, dcnt;

	dca_top DUT (.ref_clk, .resetn, .diff_clock_true, .diff_clock_comp, .clock_gate,
		.chip_select_n, .row_strobe_n, .col_strobe_n, .write_enable_n, .bank_select,
		.address_bus, .termination_enable, .write_mask, .data_strobe, .cmd_valid, .cmd_code,
		.cmd_bank, .row_addr, .col_addr, .auto_precharge, .precharge_all, .burst_chop,
		.open_banks, .clocks_enable, .buffers_enable, .self_refresh, .active_power_down,
		.precharge_power_down, .termination_on, .termination_strobe_on, .mask_mode,
		.beat_valid, .beat_discard);
	dca_ctrl_model ctrl (.diff_clock_true, .diff_clock_comp, .clock_gate, .chip_select_n,
		.row_strobe_n, .col_strobe_n, .write_enable_n, .bank_select, .address_bus,
		.termination_enable, .write_mask, .data_strobe);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// pulses are counted here so none is missed between checks
	always @(posedge ref_clk) begin
		if (cmd_valid === 1'b1) vcnt++;
		if (beat_valid === 1'b1) bcnt++;
		if (beat_valid === 1'b1 && beat_discard === 1'b1) dcnt++;
	end

	////////////////////////////////////////////////////////////////////////////////

	task tally_and_finish;
		$display("bad_count=%0d compares=%0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, g, e);
		end
	endtask

	task rst;
		resetn = 1'b0;
		repeat (16) @(posedge ref_clk);
		#1 resetn = 1'b1;
		repeat (8) @(posedge ref_clk);
		#1;
		eo = 8'h00;
		otf = 1'b0;
	endtask

	// pin edge to pulse is at most 3 cycles; drive returns 4 after the edge
	task cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a,
		input logic k, input logic o, input logic v);
		int n;
		n = vcnt;
		ctrl.drive(c, b, a, k, o);
		repeat (4) @(posedge ref_clk);
		#1;
		chk(vcnt - n, v, "pulse");
	endtask

	task act(input logic [2:0] b, input logic [14:0] a);
		cmd(dca_pkg::CMD_ACT, b, a, 1'b1, 1'b0, 1'b1);
		eo[b] = 1'b1;
		chk(row_addr, a, "row");
		chk(open_banks, eo, "open");
	endtask

	task rw(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
		int n, d;
		logic [7:0] m;
		logic bc;
		bc = otf & !a[12];
		cmd(c, b, a, 1'b1, 1'b0, 1'b1);
		chk(cmd_code, c, "code");
		chk(cmd_bank, b, "bank");
		chk(col_addr, a[9:0], "col");
		chk(auto_precharge, a[10], "autopre");
		chk(burst_chop, bc, "chop");
		if (a[10]) eo[b] = 1'b0;
		chk(open_banks, eo, "open");
		if (c == dca_pkg::CMD_WR) begin
			m = 8'($urandom);
			n = bcnt;
			d = dcnt;
			ctrl.beats(m);
			repeat (5) @(posedge ref_clk);
			#1;
			chk(bcnt - n, bc ? 4 : 8, "beats");
			chk(dcnt - d, $countones(bc ? {4'h0, m[3:0]} : m), "drops");
		end
	endtask

	initial begin
		#400000;
		bad_count++;
		$display("MISMATCH t=%0t run did not finish", $time);
		tally_and_finish();
	end

	initial begin
		logic [2:0] b;
		{resetn, bad_count, compares, vcnt, bcnt, dcnt} = '0;
		void'($urandom(52));
		rst();
		ctrl.ck_run = 1'b1;
		chk({cmd_code, open_banks, clocks_enable, mask_mode}, 14'h1C03, "reset");
		act(3'h0, 15'h5A5A);
		rw(dca_pkg::CMD_WR, 3'h0, 15'h0123);
		cmd(dca_pkg::CMD_MRS, 3'h0, 15'h0001, 1'b1, 1'b0, 1'b1);
		otf = 1'b1;
		cmd(dca_pkg::CMD_MRS, 3'h4, 15'h0000, 1'b1, 1'b0, 1'b1);
		rw(dca_pkg::CMD_WR, 3'h0, 15'h0000);
		rw(dca_pkg::CMD_WR, 3'h0, 15'h1000);
		for (int i = 0; i < 8; i++) begin
			b = 3'($urandom);
			act(b, 15'($urandom));
			rw(i[0] ? dca_pkg::CMD_RD : dca_pkg::CMD_WR, b, 15'($urandom));
		end
		cmd(4'hB, 3'h6, 15'h0000, 1'b1, 1'b0, 1'b0);
		chk(open_banks, eo, "masked");
		act(3'h3, 15'h0000);
		act(3'h5, 15'h0000);
		cmd(dca_pkg::CMD_PRE, 3'h3, 15'h0000, 1'b1, 1'b0, 1'b1);
		eo[3] = 1'b0;
		chk({precharge_all, open_banks}, {1'b0, eo}, "pre one");
		cmd(dca_pkg::CMD_PRE, 3'h0, 15'h0400, 1'b1, 1'b0, 1'b1);
		chk({precharge_all, open_banks}, 9'h100, "pre all");
		eo = 8'h00;
		cmd(dca_pkg::CMD_NOP, 3'h0, 15'h0000, 1'b1, 1'b1, 1'b1);
		chk(termination_on, 1'b0, "odt off");
		cmd(dca_pkg::CMD_MRS, 3'h1, 15'h0804, 1'b1, 1'b0, 1'b1);
		chk(mask_mode, 1'b0, "mask mode");
		cmd(dca_pkg::CMD_NOP, 3'h0, 15'h0000, 1'b1, 1'b1, 1'b1);
		chk({termination_on, termination_strobe_on}, 2'h3, "odt on");
		act(3'h2, 15'h7FFF);
		cmd(dca_pkg::CMD_NOP, 3'h0, 15'h0000, 1'b0, 1'b0, 1'b0);
		chk({active_power_down, clocks_enable, buffers_enable}, 3'h4, "act pd");
		cmd(dca_pkg::CMD_NOP, 3'h0, 15'h0000, 1'b1, 1'b0, 1'b0);
		chk({active_power_down, clocks_enable}, 2'h1, "pd exit");
		cmd(dca_pkg::CMD_PRE, 3'h0, 15'h0400, 1'b1, 1'b0, 1'b1);
		eo = 8'h00;
		chk({precharge_all, open_banks}, 9'h100, "pre all again");
		cmd(dca_pkg::CMD_NOP, 3'h0, 15'h0000, 1'b0, 1'b0, 1'b0);
		chk(precharge_power_down, 1'b1, "pre pd");
		cmd(dca_pkg::CMD_NOP, 3'h0, 15'h0000, 1'b1, 1'b0, 1'b0);
		cmd(dca_pkg::CMD_REF, 3'h0, 15'h0000, 1'b0, 1'b1, 1'b0);
		chk({self_refresh, buffers_enable, termination_on}, 3'h4, "self ref");
		ctrl.sr_exit();
		chk({self_refresh, clocks_enable}, 2'h1, "sr exit");
		act(3'h7, 15'h0001);
		rst();
		chk({cmd_code, open_banks}, 12'h700, "reset again");
		tally_and_finish();
	end
endmodule

`default_nettype wire
